// file: core/afr_pkg.sv
package afr_pkg;

    localparam logic [7:0] ADDR_ANALOG_OUTPUT_CONFIG    = 8'h06;
    localparam logic [7:0] ADDR_RESERVED_SLOT_A         = 8'h07;
    localparam logic [7:0] ADDR_FAULT_CONFIG_AND_STATUS = 8'h08;
    localparam logic [7:0] ADDR_RESERVED_RANGE_FIRST    = 8'h09;
    localparam logic [7:0] ADDR_RESERVED_RANGE_LAST     = 8'h0F;

    localparam logic [7:0] RST_ANALOG_OUTPUT_CONFIG    = 8'h51;
    localparam logic [7:0] RST_RESERVED_SLOT_A         = 8'h00;
    localparam logic [7:0] RST_FAULT_CONFIG_AND_STATUS = 8'h00;

    localparam int BIT_PARALLEL_MODE = 7;
    localparam int RATE_MSB          = 6;
    localparam int RATE_LSB          = 4;
    localparam int GAIN_MSB          = 3;
    localparam int GAIN_LSB          = 2;
    localparam int BIT_CHANNEL_SEL   = 1;
    localparam int BIT_ANALOG_RSVD   = 0;

    localparam int OC_THR_MSB        = 5;
    localparam int OC_THR_LSB        = 4;
    localparam int BIT_CLOCK_ERROR   = 3;
    localparam int BIT_OVERCURRENT   = 2;
    localparam int BIT_DC_ERROR      = 1;
    localparam int BIT_OVER_TEMP     = 0;

    // Bit clock is declared stopped after this many nanoseconds, turned
    // into system clocks below, with no edge seen.
    localparam int          BCLK_TIMEOUT_NS     = 2000;
    localparam int          CLK_PERIOD_NS       = 8;
    localparam int          BCLK_TIMEOUT_CYCLES =
        BCLK_TIMEOUT_NS / CLK_PERIOD_NS;
    localparam logic [15:0] BCLK_TIMEOUT_COUNT  =
        16'(BCLK_TIMEOUT_CYCLES);

    localparam logic [1:0] GAIN_RESERVED = 2'h3;

endpackage : afr_pkg

// file: core/afr_sync3.sv
`timescale 1ns/1ps
`default_nettype none

module afr_sync3
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic din,
    output var  logic dout
);

    logic s1;
    logic s2;
    logic s3;

    // The first stage feeds only the second; the output changes once the
    // last two stages agree.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1   <= 1'b0;
            s2   <= 1'b0;
            s3   <= 1'b0;
            dout <= 1'b0;
        end
        else
        begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3)
            begin
                dout <= s3;
            end
        end
    end

endmodule : afr_sync3

`default_nettype wire

// file: core/afr_regs.sv
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// RQ1: Output-mode bit 7 clear selects bridge-tied, set selects parallel.
// RQ2: Rate field bits 6:4 selects 6,8,10,12,14,16,20,24 times frame rate.
// RQ3: Double-speed sample rates halve the selected switching frequency.
// RQ4: Gain bits 3:2 pick 19.2, 22.6 or 25 dBV; code 11 reserved.
// RQ5: In parallel mode channel bit 1 clear uses right, set uses left.
// RQ6: Software keeps analog reserved bit 0 at its default value.
// RQ7: Software never uses reserved addresses 0x09 through 0x0F.
// RQ8: Overcurrent threshold bits 5:4 give 100, 75, 50 or 25 percent.
// RQ9: Clock error bit 3 reads high while present, clears itself after.
// RQ10: A stopped serial bit clock raises the clock error.
// RQ11: Overcurrent bit 2 latches and halts until shutdown pin toggles.
// RQ12: DC error bit 1 latches and halts until shutdown pin toggles.
// RQ13: Over-temperature latches and halts until shutdown pin toggles.
// RQ14: Writes to the status flag bits leave them unchanged.
// RQ15: Host changes settings, volume aside, only while in shutdown.
module afr_regs
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output var  logic [7:0] reg_rdata,
    output var  logic       reg_rd_valid,
    input  wire logic       speaker_shutdown_n,
    input  wire logic       serial_bit_clock,
    input  wire logic       frame_rate_clock_valid,
    input  wire logic       double_speed,
    input  wire logic       overcurrent_detect,
    input  wire logic       output_dc_detect,
    input  wire logic       over_temp_detect,
    output var  logic       parallel_bridge_mode,
    output var  logic       bridge_tied_mode,
    output var  logic [5:0] switch_ratio,
    output var  logic [1:0] analog_gain,
    output var  logic       parallel_use_left,
    output var  logic [1:0] overcurrent_threshold,
    output var  logic       clock_error,
    output var  logic       overcurrent_error,
    output var  logic       output_dc_error,
    output var  logic       over_temp_error,
    output var  logic       amp_halted
);

    logic [7:0]  analog_output_config;
    logic [7:0]  reserved_slot_a;
    logic [1:0]  oc_threshold;
    logic        sd_sync;
    logic        sd_prev;
    logic        sd_rise;
    logic        bclk_sync;
    logic        bclk_prev;
    logic [15:0] bclk_idle;
    logic        bclk_stopped;
    logic        oc_sync;
    logic        dc_sync;
    logic        ot_sync;
    logic        fr_sync;
    logic [7:0]  next_rdata;

    afr_sync3 u_sync_sd (.clk(clk), .rst_n(rst_n),
        .din(speaker_shutdown_n), .dout(sd_sync));
    afr_sync3 u_sync_bclk (.clk(clk), .rst_n(rst_n),
        .din(serial_bit_clock), .dout(bclk_sync));
    afr_sync3 u_sync_oc (.clk(clk), .rst_n(rst_n),
        .din(overcurrent_detect), .dout(oc_sync));
    afr_sync3 u_sync_dc (.clk(clk), .rst_n(rst_n),
        .din(output_dc_detect), .dout(dc_sync));
    afr_sync3 u_sync_ot (.clk(clk), .rst_n(rst_n),
        .din(over_temp_detect), .dout(ot_sync));
    afr_sync3 u_sync_fr (.clk(clk), .rst_n(rst_n),
        .din(frame_rate_clock_valid), .dout(fr_sync));

    function automatic logic [5:0] rate_multiple(input logic [2:0] code);
        logic [5:0] m;
        m = 6'h06;
        unique case (code)
            3'h0: m = 6'h06;
            3'h1: m = 6'h08;
            3'h2: m = 6'h0A;
            3'h3: m = 6'h0C;
            3'h4: m = 6'h0E;
            3'h5: m = 6'h10;
            3'h6: m = 6'h14;
            3'h7: m = 6'h18;
        endcase
        return m;
    endfunction : rate_multiple

    function automatic logic is_write(input logic [7:0] addr,
                                      input logic [7:0] target,
                                      input logic       wr);
        return wr && (addr == target);
    endfunction : is_write

    // Bit 0 is kept writable so software can restore its default.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            analog_output_config <= afr_pkg::RST_ANALOG_OUTPUT_CONFIG;
        end
        else if (is_write(reg_addr, afr_pkg::ADDR_ANALOG_OUTPUT_CONFIG,
                          reg_wr))
        begin
            analog_output_config <= reg_wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reserved_slot_a <= afr_pkg::RST_RESERVED_SLOT_A;
        end
        else if (is_write(reg_addr, afr_pkg::ADDR_RESERVED_SLOT_A, reg_wr))
        begin
            reserved_slot_a <= reg_wdata;
        end
    end

    // Only the threshold field takes write data; the flags ignore it.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            oc_threshold <= afr_pkg::RST_FAULT_CONFIG_AND_STATUS[5:4];
        end
        else if (is_write(reg_addr, afr_pkg::ADDR_FAULT_CONFIG_AND_STATUS,
                          reg_wr))
        begin
            oc_threshold <= reg_wdata[afr_pkg::OC_THR_MSB:
                                      afr_pkg::OC_THR_LSB]; // RQ8 RQ14
        end
    end

    // Bit clock watchdog: any edge restarts the idle count.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bclk_prev    <= 1'b0;
            bclk_idle    <= 16'h0000;
            bclk_stopped <= 1'b1;
        end
        else
        begin
            bclk_prev <= bclk_sync;
            if (bclk_sync != bclk_prev)
            begin
                bclk_idle    <= 16'h0000;
                bclk_stopped <= 1'b0;
            end
            else if (bclk_idle >= afr_pkg::BCLK_TIMEOUT_COUNT)
            begin
                bclk_stopped <= 1'b1; // RQ10
            end
            else
            begin
                bclk_idle <= bclk_idle + 16'h0001;
            end
        end
    end

    // Clock error follows the clock state, so it clears without help.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            clock_error <= 1'b0;
        end
        else
        begin
            clock_error <= bclk_stopped || !fr_sync; // RQ9 RQ10
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sd_prev <= 1'b0;
        end
        else
        begin
            sd_prev <= sd_sync;
        end
    end

    // A low-then-high toggle of the shutdown pin clears the latched faults.
    assign sd_rise = sd_sync && !sd_prev;

    // A fault arriving on the clearing edge wins over the clear.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            overcurrent_error <= 1'b0;
            output_dc_error   <= 1'b0;
            over_temp_error   <= 1'b0;
        end
        else
        begin
            overcurrent_error <= oc_sync || (overcurrent_error && !sd_rise);
            output_dc_error   <= dc_sync || (output_dc_error && !sd_rise);
            over_temp_error   <= ot_sync || (over_temp_error && !sd_rise);
        end
    end // RQ11 RQ12 RQ13

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            amp_halted <= 1'b1;
        end
        else
        begin
            amp_halted <= !sd_sync || clock_error || overcurrent_error ||
                          output_dc_error || over_temp_error; // RQ11 RQ15
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            parallel_bridge_mode  <= 1'b0;
            bridge_tied_mode      <= 1'b1;
            switch_ratio          <= 6'h06;
            analog_gain           <= 2'h0;
            parallel_use_left     <= 1'b0;
            overcurrent_threshold <= 2'h0;
        end
        else
        begin
            parallel_bridge_mode <=
                analog_output_config[afr_pkg::BIT_PARALLEL_MODE]; // RQ1
            bridge_tied_mode <=
                !analog_output_config[afr_pkg::BIT_PARALLEL_MODE]; // RQ1
            // Ratio is switching cycles per frame; double speed halves it.
            switch_ratio <= double_speed ?
                (rate_multiple(analog_output_config[afr_pkg::RATE_MSB:
                    afr_pkg::RATE_LSB]) >> 1) :
                rate_multiple(analog_output_config[afr_pkg::RATE_MSB:
                    afr_pkg::RATE_LSB]); // RQ2 RQ3
            // The reserved gain code is never applied; the last legal one holds.
            if (analog_output_config[afr_pkg::GAIN_MSB:afr_pkg::GAIN_LSB]
                != afr_pkg::GAIN_RESERVED)
            begin
                analog_gain <= analog_output_config[afr_pkg::GAIN_MSB:
                                                    afr_pkg::GAIN_LSB]; // RQ4
            end
            parallel_use_left <=
                analog_output_config[afr_pkg::BIT_CHANNEL_SEL]; // RQ5
            overcurrent_threshold <= oc_threshold; // RQ8
        end
    end

    always_comb
    begin
        next_rdata = 8'h00;
        unique case (reg_addr)
            afr_pkg::ADDR_ANALOG_OUTPUT_CONFIG:
                next_rdata = analog_output_config;
            afr_pkg::ADDR_RESERVED_SLOT_A:
                next_rdata = reserved_slot_a;
            afr_pkg::ADDR_FAULT_CONFIG_AND_STATUS:
                next_rdata = {2'h0, oc_threshold, clock_error,
                              overcurrent_error, output_dc_error,
                              over_temp_error}; // RQ9 RQ11 RQ12 RQ13
            default:
                next_rdata = 8'h00; // RQ7
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reg_rdata    <= 8'h00;
            reg_rd_valid <= 1'b0;
        end
        else
        begin
            reg_rd_valid <= reg_rd;
            if (reg_rd)
            begin
                reg_rdata <= next_rdata;
            end
        end
    end

endmodule : afr_regs

`default_nettype wire

// file: dv/afr_regs_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module afr_regs_asserts
(
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       speaker_shutdown_n,
    input wire logic       serial_bit_clock,
    input wire logic       frame_rate_clock_valid,
    input wire logic       parallel_bridge_mode,
    input wire logic       bridge_tied_mode,
    input wire logic [1:0] analog_gain,
    input wire logic [1:0] overcurrent_threshold,
    input wire logic       clock_error,
    input wire logic       overcurrent_error,
    input wire logic       output_dc_error,
    input wire logic       over_temp_error
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // Saturates so that a long stop never wraps into the alive range.
    logic [8:0] still_cnt;
    logic       bclk_q;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            still_cnt <= 9'h100;
            bclk_q    <= 1'b0;
        end
        else
        begin
            bclk_q    <= serial_bit_clock;
            still_cnt <= (serial_bit_clock != bclk_q) ? 9'h000 :
                         still_cnt + {8'h00, still_cnt != 9'h1FF};
        end
    end
    property p_mode;
        bridge_tied_mode != parallel_bridge_mode;
    endproperty
    a_mode: assert property (p_mode) else $error("mode clash");
    property p_gain;
        analog_gain != 2'h3;
    endproperty
    a_gain: assert property (p_gain) else $error("gain 3 used");
    property p_thr;
        reg_wr && reg_addr == 8'h08 ##1 !reg_wr
            |=> overcurrent_threshold == $past(reg_wdata[5:4], 2);
    endproperty
    a_thr: assert property (p_thr) else $error("bad threshold");
    property p_oc;
        speaker_shutdown_n[*8] ##0 overcurrent_error |=> overcurrent_error;
    endproperty
    a_oc: assert property (p_oc) else $error("oc flag lost");
    property p_dc;
        speaker_shutdown_n[*8] ##0 output_dc_error |=> output_dc_error;
    endproperty
    a_dc: assert property (p_dc) else $error("dc flag lost");
    property p_ot;
        speaker_shutdown_n[*8] ##0 over_temp_error |=> over_temp_error;
    endproperty
    a_ot: assert property (p_ot) else $error("temp flag lost");
    property p_stop;
        still_cnt >= 9'h10E |-> clock_error;
    endproperty
    a_stop: assert property (p_stop) else $error("no clock error");
    property p_alive;
        frame_rate_clock_valid[*8] ##0 still_cnt < 9'h014
            && $past(still_cnt, 8) < 9'h014 |-> !clock_error;
    endproperty
    a_alive: assert property (p_alive) else $error("stuck clock err");
endmodule : afr_regs_asserts
bind afr_regs afr_regs_asserts afr_regs_asserts_i (.clk, .rst_n, .reg_wr,
    .reg_addr, .reg_wdata, .speaker_shutdown_n, .serial_bit_clock,
    .frame_rate_clock_valid, .parallel_bridge_mode, .bridge_tied_mode,
    .analog_gain, .overcurrent_threshold, .clock_error,
    .overcurrent_error, .output_dc_error, .over_temp_error);
`default_nettype wire

// file: dv/tb_amp_analog_fault_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tb_amp_analog_fault_regs;
    localparam logic [5:0] RATE [8] = '{6'h06, 6'h08, 6'h0A, 6'h0C,
                                        6'h0E, 6'h10, 6'h14, 6'h18};
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic       speaker_shutdown_n = 1'b0;
    logic       serial_bit_clock = 1'b0;
    logic       frame_rate_clock_valid = 1'b1;
    logic       double_speed = 1'b0;
    logic       bclk_run = 1'b1;
    logic [1:0] bclk_div = 2'h0;
    logic [2:0] det = 3'h0;
    logic [3:0] err;
    logic [7:0] reg_rdata;
    logic [5:0] switch_ratio;
    logic [1:0] analog_gain, overcurrent_threshold;
    logic       reg_rd_valid, parallel_bridge_mode, bridge_tied_mode;
    logic       parallel_use_left, amp_halted;
    int         mismatches = 0;
    int         cmp_count = 0;
    afr_regs afr_regs_i (.clk, .rst_n, .reg_wr, .reg_rd, .reg_addr,
        .reg_wdata, .reg_rdata, .reg_rd_valid, .speaker_shutdown_n,
        .serial_bit_clock, .frame_rate_clock_valid, .double_speed,
        .overcurrent_detect(det[2]), .output_dc_detect(det[1]),
        .over_temp_detect(det[0]), .parallel_bridge_mode,
        .bridge_tied_mode, .switch_ratio, .analog_gain,
        .parallel_use_left, .overcurrent_threshold,
        .clock_error(err[3]), .overcurrent_error(err[2]),
        .output_dc_error(err[1]), .over_temp_error(err[0]), .amp_halted);
    initial
    begin
        forever #4 clk = ~clk;
    end
    // The pin holds each level for four clocks, since the synchroniser
    // only passes a level that two of its stages agree on.
    always @(posedge clk)
    begin
        bclk_div <= bclk_div + 2'h1;
        if (bclk_run && bclk_div == 2'h3)
            serial_bit_clock <= ~serial_bit_clock;
    end
    task automatic give_verdict;
        $display("Compares %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH at %0t: got %h, want %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
        @(posedge clk);
    endtask : wr
    // Read data is looked at in the one cycle that its valid flag stands.
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        chk({reg_rd_valid, reg_rdata}, {1'b1, e});
        @(posedge clk);
    endtask : rd
    task automatic wait_err(input int i, input logic v);
        int n;
        for (n = 0; n < 400 && err[i] !== v; n++)
            @(posedge clk);
        chk({8'h00, err[i]}, {8'h00, v});
        if (n == 400) give_verdict();
    endtask : wait_err
    task automatic t_analog;
        for (int c = 0; c < 8; c++)
        begin
            wr(8'h06, {1'b1, 3'(c), 4'h7});
            for (int d = 0; d < 2; d++)
            begin
                double_speed <= 1'(d);
                repeat (3) @(posedge clk);
                chk({3'h0, switch_ratio}, {3'h0, RATE[c] >> d});
            end
        end
        double_speed <= 1'b0;
        chk({6'h00, parallel_bridge_mode, bridge_tied_mode,
             parallel_use_left}, 9'h005);
        // Software never writes the reserved gain code.
        for (int g = 0; g < 3; g++)
        begin
            wr(8'h06, {4'h2, 2'(g), 2'h1});
            repeat (2) @(posedge clk);
            chk({7'h00, analog_gain}, 9'(g));
        end
        chk({6'h00, parallel_bridge_mode, bridge_tied_mode,
             parallel_use_left}, 9'h002);
    endtask : t_analog
    task automatic t_regs;
        // Software keeps away from the reserved range above the fault byte.
        for (int a = 0; a < 7; a++)
        begin
            wr(8'h07, ~8'(a));
            rd(8'h07, ~8'(a));
        end
        for (int t = 0; t < 4; t++)
        begin
            wr(8'h08, {2'h3, 2'(t), 4'hF});
            rd(8'h08, {2'h0, 2'(t), 4'h0});
            chk({7'h00, overcurrent_threshold}, 9'(t));
        end
    endtask : t_regs
    task automatic t_clock;
        bclk_run <= 1'b0;
        repeat (240) @(posedge clk);
        chk({8'h00, err[3]}, 9'h000);
        wait_err(3, 1'b1);
        rd(8'h08, 8'h38);
        bclk_run <= 1'b1;
        wait_err(3, 1'b0);
        frame_rate_clock_valid <= 1'b0;
        wait_err(3, 1'b1);
        frame_rate_clock_valid <= 1'b1;
        wait_err(3, 1'b0);
    endtask : t_clock
    task automatic t_latch;
        speaker_shutdown_n <= 1'b1;
        for (int i = 0; i < 3; i++)
        begin
            det[i] <= 1'b1;
            repeat (8) @(posedge clk);
            det[i] <= 1'b0;
            wait_err(i, 1'b1);
            repeat (20) @(posedge clk);
            chk({7'h00, err[i], amp_halted}, 9'h003);
            rd(8'h08, {4'h3, 4'(1 << i)});
            speaker_shutdown_n <= 1'b0;
            repeat (10) @(posedge clk);
            speaker_shutdown_n <= 1'b1;
            wait_err(i, 1'b0);
        end
        repeat (8) @(posedge clk);
        chk({8'h00, amp_halted}, 9'h000);
    endtask : t_latch
    initial
    begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(8'h06, 8'h51);
        rd(8'h07, 8'h00);
        wait_err(3, 1'b0);
        rd(8'h08, 8'h00);
        t_analog();
        t_regs();
        t_clock();
        t_latch();
        give_verdict();
    end
endmodule : tb_amp_analog_fault_regs
`default_nettype wire
